// File: rtl/host_config_cfg.svh
// constants of the configuration message checker: offsets, codes, defaults
`ifndef HOST_CONFIG_CFG_SVH
`define HOST_CONFIG_CFG_SVH

// ==========================================
// register map, word indices (byte address = 4 * index)
`define MSG_WORDS 5'd20
`define IDX_CTRL 5'd20
`define IDX_STATUS 5'd21
`define IDX_HDR 5'd1
`define IDX_OPT 5'd2
`define IDX_MODE3 5'd3
`define IDX_TP 5'd4
`define IDX_BLOCK 5'd12
`define IDX_COUNTS 5'd13
`define IDX_HQ_BASE 5'd14
`define IDX_HQ_HDR 5'd15
`define IDX_HQ_IADDR 5'd16

// ==========================================
// completion codes
`define CC_PENDING 8'hFF
`define CC_OK 8'h00
`define CC_BAD_MODE 8'hA4
`define CC_BAD_PATTERN 8'hA5
`define CC_BAD_BLOCK 8'hA8
`define CC_BAD_PROC 8'hA9
`define CC_BAD_MBOX 8'hAA
`define CC_BAD_SLOT 8'hAB
`define CC_BAD_HOST 8'hAC
`define CC_BAD_QUEUE 8'hAD
`define CC_NO_MEM 8'hAE

// ==========================================
// field values and limits
`define KEEP_BYTE 8'hFF
`define KEEP_BLOCK 32'hFFFF_FFFF
`define MODE_LINK 8'h00
`define MODE_HOST_DL 8'h01
`define MODE_NET_DL 8'h02
`define COUNT_MAX 8'h80
`define SLOT_MAX 8'hFC
`define ITYPE_POLL 8'h00
`define ITYPE_MEM 8'h02
`define ITYPE_VEC 8'h04
`define LOW_LO 17'h0_0200
`define LOW_HI 17'h0_03FF
`define HIGH_LO 17'h0_1000
`define HIGH_HI 17'h0_FFFF

// ==========================================
// reset values of the settings in force
`define PROC_RESET 8'h0C
`define MBOX_RESET 8'h10
`define SLOT_RESET 8'h08
`define HOST_RESET 8'h00

// ==========================================
// board-side values used in the checks and returned in the reply
`define CONTEXT_VALUE 8'h5A // arbitrary board context value
`define TEST_PATTERN 32'h0403_0201
`define BLOCK_SIZE 17'h0_0100
`define BLOCK_DEFAULT 32'h0000_2000
`define MEM_BUDGET 9'h0C8
`define MAP_COUNT 8'h02
`define MAP_LO0 32'h0000_4000
`define MAP_HI0 32'h0000_7FFF
`define MAP_LO1 32'h0000_8000
`define MAP_HI1 32'h0000_FFFF

`endif

// File: rtl/host_config_pkg.sv
// types of the configuration message checker
package host_config_pkg;
	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_REPLY = 4'b0100,
		ST_COMPLETE = 4'b1000
	} seq_state_e;
endpackage

// File: rtl/host_config_message_checker.sv
// configuration message buffer, field checker and reply writer
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
`include "host_config_cfg.svh"
module host_config_message_checker
	import host_config_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// host notification request from device logic
	input wire logic notify_i,
	output logic notify_wr_o,
	output logic [31:0] notify_addr_o,
	output logic [7:0] notify_data_o,
	output logic notify_vec_o,
	output logic [15:0] notify_vector_o,
	// settings in force
	output logic cfg_valid_o,
	output logic conv_swap_o,
	output logic [7:0] proc_count_o,
	output logic [7:0] mbox_count_o,
	output logic [7:0] slot_count_o,
	output logic [7:0] host_count_o,
	output logic [31:0] block_addr_o,
	output logic [5:0] hq_modifier_o,
	output logic [23:0] hq_header_addr_o,
	output logic [7:0] hq_int_type_o
);
	// ==========================================
	// storage
	logic [31:0] msg_mem [0:19];
	seq_state_e state_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic conv_reg;
	logic cfg_valid_reg;
	logic [7:0] proc_reg, mbox_reg, slot_reg, host_reg, code_reg;
	logic [31:0] block_reg, iaddr_reg;
	logic [7:0] itype_reg, ival_reg;
	logic [5:0] modifier_reg;
	logic [23:0] header_reg;
	logic wr_reg, vec_reg;
	logic [31:0] waddr_reg;
	logic [7:0] wdata_reg;
	logic [15:0] vector_reg;

	// byte swap inside each halfword
	function automatic logic [31:0] swap16(input logic [31:0] w);
		swap16 = {w[23:16], w[31:24], w[7:0], w[15:8]};
	endfunction

	// memory map descriptor words for the reply
	function automatic logic [31:0] map_word(input int unsigned i);
		case (i)
			0: map_word = `MAP_LO0;
			1: map_word = `MAP_HI0;
			2: map_word = `MAP_LO1;
			3: map_word = `MAP_HI1;
			default: map_word = 32'h0000_0000;
		endcase
	endfunction

	// ==========================================
	// bus decode
	logic bus_req;
	logic [4:0] bus_idx;
	logic idle;
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign bus_idx = wb_adr_i[6:2];
	assign idle = (state_reg == ST_IDLE);

	// ==========================================
	// field decode and checks
	logic [7:0] mode, opt, proc_in, mbox_in, slot_in, host_in, itype_in, ival_in;
	logic conv_next, pat_bad, blk_keep, blk_bad, q_bad, mem_bad;
	logic [31:0] blk_in, base_in, iaddr_in, blk_eff;
	logic [15:0] hdr_in;
	logic [16:0] blk_end;
	logic [7:0] proc_eff, mbox_eff, slot_eff, host_eff, code_next;
	logic [8:0] mem_need;
	always_comb begin
		mode = msg_mem[`IDX_HDR][31:24];
		// either half is taken, the two halves ORed together
		opt = msg_mem[`IDX_OPT][7:0] | msg_mem[`IDX_OPT][15:8];
		pat_bad = 1'b0;
		conv_next = conv_reg;
		if (opt[0]) begin
			if (msg_mem[`IDX_TP] == `TEST_PATTERN) begin
				conv_next = 1'b0;
			end else if (msg_mem[`IDX_TP] == swap16(`TEST_PATTERN)) begin
				conv_next = 1'b1;
			end else begin
				pat_bad = 1'b1;
			end
		end
		// every multi-byte field is read under the new conversion
		blk_in = conv_next ? swap16(msg_mem[`IDX_BLOCK]) : msg_mem[`IDX_BLOCK];
		base_in = conv_next ? swap16(msg_mem[`IDX_HQ_BASE]) : msg_mem[`IDX_HQ_BASE];
		hdr_in = conv_next ? {msg_mem[`IDX_HQ_HDR][7:0], msg_mem[`IDX_HQ_HDR][15:8]} : msg_mem[`IDX_HQ_HDR][15:0];
		iaddr_in = conv_next ? swap16(msg_mem[`IDX_HQ_IADDR]) : msg_mem[`IDX_HQ_IADDR];
		itype_in = msg_mem[`IDX_HQ_HDR][23:16];
		ival_in = msg_mem[`IDX_HQ_HDR][31:24];
		proc_in = msg_mem[`IDX_COUNTS][7:0];
		mbox_in = msg_mem[`IDX_COUNTS][15:8];
		slot_in = msg_mem[`IDX_COUNTS][23:16];
		host_in = msg_mem[`IDX_COUNTS][31:24];
		// movable block: all ones keeps default, else segment zero and window fit, and never in link mode
		blk_keep = (blk_in == `KEEP_BLOCK);
		blk_end = {1'b0, blk_in[15:0]} + `BLOCK_SIZE - 17'h0_0001;
		blk_bad = !blk_keep && ((mode == `MODE_LINK) || (blk_in[31:16] != 16'h0000) ||
			!((({1'b0, blk_in[15:0]} >= `LOW_LO) && (blk_end <= `LOW_HI)) ||
			(({1'b0, blk_in[15:0]} >= `HIGH_LO) && (blk_end <= `HIGH_HI))));
		blk_eff = blk_keep ? `BLOCK_DEFAULT : blk_in;
		proc_eff = (proc_in == `KEEP_BYTE) ? proc_reg : proc_in;
		mbox_eff = (mbox_in == `KEEP_BYTE) ? mbox_reg : mbox_in;
		slot_eff = (slot_in == `KEEP_BYTE) ? slot_reg : slot_in;
		host_eff = (host_in == `KEEP_BYTE) ? host_reg : host_in;
		mem_need = {1'b0, proc_eff} + {1'b0, mbox_eff};
		mem_bad = (mode != `MODE_LINK) && (mem_need > `MEM_BUDGET);
		// queue base: top two bits zero, 16-byte aligned; type 0, 2 or 4
		q_bad = (base_in[31:30] != 2'b00) || (base_in[3:0] != 4'h0) ||
			!((itype_in == `ITYPE_POLL) || (itype_in == `ITYPE_MEM) || (itype_in == `ITYPE_VEC));
		// error priority chain, first failing field reports
		if (mode > `MODE_NET_DL) begin
			code_next = `CC_BAD_MODE;
		end else if (pat_bad) begin
			code_next = `CC_BAD_PATTERN;
		end else if (blk_bad) begin
			code_next = `CC_BAD_BLOCK;
		end else if (((mode == `MODE_LINK) && (proc_in != `KEEP_BYTE)) ||
			((mode != `MODE_LINK) && (proc_in != `KEEP_BYTE) &&
			((proc_in == 8'h00) || (proc_in > `COUNT_MAX)))) begin
			code_next = `CC_BAD_PROC;
		end else if (((mode == `MODE_LINK) && (mbox_in != `KEEP_BYTE)) ||
			((mode != `MODE_LINK) && (mbox_in != `KEEP_BYTE) &&
			((mbox_in == 8'h00) || (mbox_in > `COUNT_MAX)))) begin
			code_next = `CC_BAD_MBOX;
		end else if ((slot_in != `KEEP_BYTE) && (slot_in > `SLOT_MAX)) begin
			code_next = `CC_BAD_SLOT;
		end else if ((host_in != `KEEP_BYTE) && (host_in != 8'h01) &&
			!((mode == `MODE_NET_DL) && (host_in == 8'h00))) begin
			code_next = `CC_BAD_HOST;
		end else if ((host_eff != 8'h00) && q_bad) begin
			code_next = `CC_BAD_QUEUE;
		end else if (mem_bad) begin
			code_next = `CC_NO_MEM;
		end else begin
			code_next = `CC_OK;
		end
	end

	// ==========================================
	// sequencer: check, write reply, then completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (bus_req && wb_we_i && !wb_adr_i[7] && (bus_idx == `IDX_CTRL) && wb_sel_i[0] && wb_dat_i[0]) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: state_reg <= ST_REPLY;
				ST_REPLY: state_reg <= ST_COMPLETE;
				ST_COMPLETE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// result code latched at the check step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_reg <= `CC_PENDING;
		end else if (state_reg == ST_CHECK) begin
			code_reg <= code_next;
		end
	end

	// ==========================================
	// message buffer: bus writes while idle, reply writes by the sequencer
	always_ff @(posedge clk_i) begin
		if (state_reg == ST_REPLY && code_reg == `CC_OK) begin
			msg_mem[`IDX_OPT][31:24] <= `CONTEXT_VALUE;
			msg_mem[`IDX_MODE3][31:24] <= `MAP_COUNT;
			for (int unsigned i = 0; i < 8; i++) begin
				msg_mem[`IDX_TP + i[4:0]] <= map_word(i);
			end
			msg_mem[`IDX_BLOCK] <= conv_reg ? swap16(block_reg) : block_reg;
			msg_mem[`IDX_COUNTS][23:0] <= {slot_reg, mbox_reg, proc_reg};
		end else if (state_reg == ST_COMPLETE) begin
			msg_mem[`IDX_HDR][23:16] <= code_reg;
		end else if (idle && bus_req && wb_we_i && !wb_adr_i[7] && (bus_idx < `MSG_WORDS)) begin
			for (int unsigned b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					msg_mem[bus_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
		end
	end

	// ==========================================
	// settings in force, updated only on a clean check
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_reg <= 1'b0;
			cfg_valid_reg <= 1'b0;
			proc_reg <= `PROC_RESET;
			mbox_reg <= `MBOX_RESET;
			slot_reg <= `SLOT_RESET;
			host_reg <= `HOST_RESET;
			block_reg <= `BLOCK_DEFAULT;
			modifier_reg <= 6'h00;
			header_reg <= 24'h00_0000;
			itype_reg <= `ITYPE_POLL;
			ival_reg <= 8'h00;
			iaddr_reg <= 32'h0000_0000;
		end else if (state_reg == ST_CHECK && code_next == `CC_OK) begin
			conv_reg <= conv_next;
			cfg_valid_reg <= 1'b1;
			proc_reg <= proc_eff;
			mbox_reg <= mbox_eff;
			slot_reg <= slot_eff;
			host_reg <= host_eff;
			block_reg <= blk_eff;
			modifier_reg <= base_in[29:24];
			header_reg <= base_in[23:0] + {8'h00, hdr_in};
			itype_reg <= (host_eff != 8'h00) ? itype_in : `ITYPE_POLL;
			ival_reg <= ival_in;
			iaddr_reg <= iaddr_in;
		end
	end

	// ==========================================
	// host notification on the configured interrupt type
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_reg <= 1'b0;
			vec_reg <= 1'b0;
			waddr_reg <= 32'h0000_0000;
			wdata_reg <= 8'h00;
			vector_reg <= 16'h0000;
		end else begin
			wr_reg <= notify_i && cfg_valid_reg && (host_reg != 8'h00) && (itype_reg == `ITYPE_MEM);
			vec_reg <= notify_i && cfg_valid_reg && (host_reg != 8'h00) && (itype_reg == `ITYPE_VEC);
			if (notify_i) begin
				waddr_reg <= iaddr_reg;
				wdata_reg <= ival_reg;
				vector_reg <= iaddr_reg[15:0];
			end
		end
	end

	// ==========================================
	// bus answer: ack one cycle after request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			if (bus_req && !wb_we_i) begin
				if (wb_adr_i[7] == 1'b0 && bus_idx < `MSG_WORDS) begin
					rdat_reg <= msg_mem[bus_idx];
				end else if (wb_adr_i[7] == 1'b0 && bus_idx == `IDX_STATUS) begin
					rdat_reg <= {16'h0000, code_reg, 5'h00, conv_reg, cfg_valid_reg, !idle};
				end else begin
					rdat_reg <= 32'h0000_0000;
				end
			end
		end
	end

	// ==========================================
	// output wiring from flip-flops
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign notify_wr_o = wr_reg;
	assign notify_addr_o = waddr_reg;
	assign notify_data_o = wdata_reg;
	assign notify_vec_o = vec_reg;
	assign notify_vector_o = vector_reg;
	assign cfg_valid_o = cfg_valid_reg;
	assign conv_swap_o = conv_reg;
	assign proc_count_o = proc_reg;
	assign mbox_count_o = mbox_reg;
	assign slot_count_o = slot_reg;
	assign host_count_o = host_reg;
	assign block_addr_o = block_reg;
	assign hq_modifier_o = modifier_reg;
	assign hq_header_addr_o = header_reg;
	assign hq_int_type_o = itype_reg;

	// ==========================================
	// assertions
	property p_seq_order;
		@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_CHECK |=> state_reg == ST_REPLY ##1 state_reg == ST_COMPLETE ##1 state_reg == ST_IDLE;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("sequence order broken");

	property p_completion_written;
		@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_COMPLETE |=> msg_mem[`IDX_HDR][23:16] == $past(code_reg);
	endproperty
	a_completion_written: assert property (p_completion_written) else $error("completion byte wrong");

	property p_context_reply;
		@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_REPLY && code_reg == `CC_OK |=> msg_mem[`IDX_OPT][31:24] == `CONTEXT_VALUE;
	endproperty
	a_context_reply: assert property (p_context_reply) else $error("context byte missing");

	property p_proc_range;
		@(posedge clk_i) disable iff (rst_i)
		cfg_valid_reg |-> proc_reg != 8'h00 && proc_reg <= `COUNT_MAX && mbox_reg != 8'h00 && mbox_reg <= `COUNT_MAX;
	endproperty
	a_proc_range: assert property (p_proc_range) else $error("count out of range");

	property p_slot_range;
		@(posedge clk_i) disable iff (rst_i)
		slot_reg <= `SLOT_MAX;
	endproperty
	a_slot_range: assert property (p_slot_range) else $error("slot count out of range");

	property p_host_range;
		@(posedge clk_i) disable iff (rst_i)
		host_reg <= 8'h01;
	endproperty
	a_host_range: assert property (p_host_range) else $error("host count out of range");

	property p_notify_mem;
		@(posedge clk_i) disable iff (rst_i)
		notify_wr_o |-> $past(itype_reg) == `ITYPE_MEM && notify_data_o == $past(ival_reg) &&
			notify_addr_o == $past(iaddr_reg) && !notify_vec_o;
	endproperty
	a_notify_mem: assert property (p_notify_mem) else $error("memory notify wrong");

	property p_notify_vec;
		@(posedge clk_i) disable iff (rst_i)
		notify_vec_o |-> $past(itype_reg) == `ITYPE_VEC && notify_vector_o == $past(iaddr_reg[15:0]);
	endproperty
	a_notify_vec: assert property (p_notify_vec) else $error("vector notify wrong");

	property p_itype_legal;
		@(posedge clk_i) disable iff (rst_i)
		itype_reg == `ITYPE_POLL || itype_reg == `ITYPE_MEM || itype_reg == `ITYPE_VEC;
	endproperty
	a_itype_legal: assert property (p_itype_legal) else $error("illegal interrupt type in force");

	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("bus ack timing wrong");

	c_config_ok: cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_COMPLETE && code_reg == `CC_OK);
	c_config_err: cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_COMPLETE && code_reg != `CC_OK);
	c_swap: cover property (@(posedge clk_i) disable iff (rst_i) $rose(conv_reg));
	c_notify: cover property (@(posedge clk_i) disable iff (rst_i) notify_wr_o);
endmodule

// File: verification/host_bus_model.sv
// host-side bus model: writes the configuration request and polls for completion
`timescale 1ns/1ns
module host_bus_model (
	// clock
	input wire logic clk_i,
	// wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i
);
	// ==========================================
	// idle bus at time zero
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end

	// ==========================================
	// host data format: byte swap inside each halfword when sw is set
	function automatic logic [31:0] cv(input logic [31:0] x, input logic sw);
		return sw ? {x[23:16], x[31:24], x[7:0], x[15:8]} : x;
	endfunction

	// test pattern as stored by a straight, a swapped or a confused host
	function automatic logic [31:0] pat_word(input logic [1:0] p);
		return (p == 2'd0) ? 32'h0403_0201 : (p == 2'd1) ? 32'h0304_0102 : 32'h1111_1111;
	endfunction

	// ==========================================
	// one classic cycle, held until ack is seen high at an edge
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_sel_o <= 4'hF;
		wb_dat_o <= d;
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		wb_adr_o <= ~a; // released lines stop showing the old value
		wb_dat_o <= ~d;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	// ==========================================
	// build the request, start the check, wait for the completion code
	task automatic send_cfg(input logic [7:0] mode, input logic [15:0] opt, input logic [1:0] pat,
		input logic sw, input logic [31:0] blk, input logic [31:0] cnt, input logic [31:0] base,
		input logic [31:0] w15, output logic [7:0] code);
		logic [31:0] q;
		logic [31:0] h;
		h = cv(w15, sw);
		wr(8'h04, {mode, 8'hFF, 16'h0000});
		wr(8'h08, {16'h0000, opt});
		wr(8'h0C, 32'h0000_0300);
		wr(8'h10, pat_word(pat));
		wr(8'h30, cv(blk, sw));
		wr(8'h34, cnt);
		wr(8'h38, cv(base, sw));
		wr(8'h3C, {w15[31:16], h[15:0]});
		wr(8'h40, cv(32'h0012_3456, sw));
		wr(8'h50, 32'h0000_0001);
		do xfer(1'b0, 8'h54, 32'h0, q); while (q[0] !== 1'b0);
		xfer(1'b0, 8'h04, 32'h0, q);
		code = q[23:16];
	endtask
endmodule

// File: verification/tb_top.sv
// top-level bench of the configuration message checker
`timescale 1ns/1ns
`include "host_config_cfg.svh"
module tb_top;
	typedef struct {
		logic [7:0] mode; logic [15:0] opt; logic [1:0] pat; logic sw;
		logic [31:0] blk; logic [31:0] cnt; logic [31:0] base; logic [31:0] w15;
		logic [7:0] code; logic [31:0] keep;
	} row_s;
	localparam logic [31:0] FF = 32'hFFFF_FFFF;
	localparam logic [31:0] B = 32'h0D00_1000;
	localparam logic [31:0] W2 = 32'h7702_0040;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, notify_i, notify_wr_o, notify_vec_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, notify_addr_o, block_addr_o, q, eb;
	logic [7:0] notify_data_o, proc_count_o, mbox_count_o, slot_count_o, host_count_o, hq_int_type_o, code;
	logic [15:0] notify_vector_o;
	logic cfg_valid_o, conv_swap_o;
	logic [5:0] hq_modifier_o;
	logic [23:0] hq_header_addr_o;
	int n_errors = 0, checks = 0, cycles = 0;
	row_s rows [23];
	row_s r;

	// ==========================================
	// design and host model
	host_config_message_checker u_host_config_message_checker (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.notify_i(notify_i), .notify_wr_o(notify_wr_o), .notify_addr_o(notify_addr_o),
		.notify_data_o(notify_data_o), .notify_vec_o(notify_vec_o), .notify_vector_o(notify_vector_o),
		.cfg_valid_o(cfg_valid_o), .conv_swap_o(conv_swap_o), .proc_count_o(proc_count_o),
		.mbox_count_o(mbox_count_o), .slot_count_o(slot_count_o), .host_count_o(host_count_o),
		.block_addr_o(block_addr_o), .hq_modifier_o(hq_modifier_o), .hq_header_addr_o(hq_header_addr_o),
		.hq_int_type_o(hq_int_type_o));
	host_bus_model u_host_bus_model (.clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
		.wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
		.wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o));

	// ==========================================
	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors = n_errors + 1;
			$display("ERROR at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	// ==========================================
	// comparison, bus read, verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks = checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		u_host_bus_model.xfer(1'b0, a, 32'h0, d);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// settings in force after any reset
	task automatic reset_chk();
		chk({host_count_o, slot_count_o, mbox_count_o, proc_count_o}, 32'h0008_100C, "reset counts");
		chk(block_addr_o, `BLOCK_DEFAULT, "reset block");
		chk(32'({cfg_valid_o, conv_swap_o}), 32'h0, "reset flags");
		rd(8'h54, q);
		chk(32'(q[15:8]), 32'(`CC_PENDING), "reset status");
	endtask

	// one notification request, outputs looked at in the answer cycle
	task automatic ping(input logic ew, input logic ev);
		notify_i <= 1'b1;
		@(posedge clk_i);
		notify_i <= 1'b0;
		#1;
		chk(32'({notify_wr_o, notify_vec_o}), 32'({ew, ev}), "notify kind");
		if (ew) chk({notify_data_o, notify_addr_o[23:0]}, 32'h7712_3456, "notify write");
		if (ev) chk(32'(notify_vector_o), 32'h3456, "notify vector");
		@(posedge clk_i);
	endtask

	// ==========================================
	// main sequence
	initial begin
		rows = '{
			'{8'h03, 16'h0101, 2'd0, 1'b0, FF, FF, B, W2, `CC_BAD_MODE, 32'h0008_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'h01FF_FFFF, B, W2, `CC_OK, 32'h0108_100C},
			'{8'h01, 16'h0001, 2'd2, 1'b0, FF, FF, B, W2, `CC_BAD_PATTERN, 32'h0108_100C},
			'{8'h01, 16'h0100, 2'd1, 1'b1, FF, FF, B, W2, `CC_OK, 32'h0108_100C},
			'{8'h01, 16'h0000, 2'd1, 1'b1, 32'h0000_1000, FF, B, W2, `CC_OK, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, 32'h0001_0200, FF, B, W2, `CC_BAD_BLOCK, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, 32'h0000_0301, FF, B, W2, `CC_BAD_BLOCK, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, 32'h0000_0300, 32'hFFFF_FF81, B, W2, `CC_BAD_PROC, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'hFFFF_00FF, B, W2, `CC_BAD_MBOX, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'hFFFD_FFFF, B, W2, `CC_BAD_SLOT, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'h02FF_FFFF, B, W2, `CC_BAD_HOST, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'h00FF_FFFF, B, W2, `CC_BAD_HOST, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, FF, 32'h4D00_1000, W2, `CC_BAD_QUEUE, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, FF, 32'h0D00_1008, W2, `CC_BAD_QUEUE, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, FF, B, 32'h7703_0040, `CC_BAD_QUEUE, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, FF, 32'hFFFF_8080, B, W2, `CC_NO_MEM, 32'h0108_100C},
			'{8'h01, 16'h0101, 2'd0, 1'b0, 32'h0000_0300, 32'hFFFC_4080, B, W2, `CC_OK, 32'h01FC_4080},
			'{8'h00, 16'h0101, 2'd0, 1'b0, 32'h0000_0300, FF, B, W2, `CC_BAD_BLOCK, 32'h01FC_4080},
			'{8'h00, 16'h0101, 2'd0, 1'b0, FF, 32'hFFFF_FF0C, B, W2, `CC_BAD_PROC, 32'h01FC_4080},
			'{8'h00, 16'h0101, 2'd0, 1'b0, FF, 32'hFFFF_10FF, B, W2, `CC_BAD_MBOX, 32'h01FC_4080},
			'{8'h00, 16'h0101, 2'd0, 1'b0, FF, 32'hFF00_FFFF, B, W2, `CC_OK, 32'h0100_4080},
			'{8'h02, 16'h0101, 2'd0, 1'b0, FF, 32'h00FF_FFFF, 32'h4D00_1008, 32'h7703_0040, `CC_OK, 32'h0000_4080},
			'{8'h02, 16'h0101, 2'd0, 1'b0, FF, 32'h01FF_FFFF, B, 32'h7704_0040, `CC_OK, 32'h0100_4080}};
		rst_i = 1'b1;
		notify_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		reset_chk();
		$display("test reset done");
		for (int i = 0; i < 23; i++) begin
			r = rows[i];
			u_host_bus_model.send_cfg(r.mode, r.opt, r.pat, r.sw, r.blk, r.cnt, r.base, r.w15, code);
			chk(32'(code), 32'(r.code), "completion code");
			chk({host_count_o, slot_count_o, mbox_count_o, proc_count_o}, r.keep, "counts");
			rd(8'h08, q);
			chk(32'(q[31:24]), (r.code === `CC_OK) ? 32'(`CONTEXT_VALUE) : 32'h0, "context");
			rd(8'h10, q);
			chk(q, (r.code === `CC_OK) ? `MAP_LO0 : u_host_bus_model.pat_word(r.pat), "map");
			if (r.code === `CC_OK) begin
				eb = (r.blk === FF) ? `BLOCK_DEFAULT : r.blk;
				chk(32'({cfg_valid_o, conv_swap_o}), 32'({1'b1, r.sw}), "swap");
				rd(8'h0C, q);
				chk(32'(q[31:24]), 32'(`MAP_COUNT), "map size");
				rd(8'h34, q);
				chk(32'(q[23:0]), 32'(r.keep[23:0]), "reply counts");
				rd(8'h3C, q);
				chk(32'(q[31:16]), 32'(r.w15[31:16]), "type echo");
				if (r.mode !== `MODE_LINK) begin
					chk(block_addr_o, eb, "block");
					rd(8'h30, q);
					chk(q, u_host_bus_model.cv(eb, r.sw), "reply block");
				end
			end
			$display("test row %0d done", i);
		end
		ping(1'b0, 1'b1);
		u_host_bus_model.send_cfg(8'h01, 16'h0101, 2'd0, 1'b0, FF, FF, B, W2, code);
		chk({hq_int_type_o, hq_header_addr_o}, 32'h0200_1040, "header address");
		chk(32'(hq_modifier_o), 32'h0D, "modifier");
		ping(1'b1, 1'b0);
		u_host_bus_model.send_cfg(8'h01, 16'h0101, 2'd0, 1'b0, FF, FF, B, 32'h7700_0040, code);
		ping(1'b0, 1'b0);
		$display("test notify done");
		rd(8'h60, q);
		chk(q, 32'h0, "unmapped read");
		rd(8'h80, q);
		chk(q, 32'h0, "high unmapped read");
		rd(8'h50, q);
		chk(q, 32'h0, "start reads zero");
		u_host_bus_model.wr(8'h00, 32'h1234_5678);
		u_host_bus_model.wr(8'h80, 32'hA5A5_A5A5);
		rd(8'h00, q);
		chk(q, 32'h1234_5678, "high write ignored");
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		reset_chk();
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
